//--- rtl/ofd_pkg.sv
package ofd_pkg;

  // ----------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [7:0] OFF_BANK    = 8'h00;
  localparam logic [7:0] OFF_WORK    = 8'h04;
  localparam logic [7:0] OFF_FLAGS   = 8'h08;
  localparam logic [7:0] OFF_TABLE_POINTER  = 8'h0C;
  localparam logic [7:0] OFF_TBLLAT  = 8'h10;
  localparam logic [7:0] OFF_PRODUCT = 8'h14;
  localparam logic [7:0] OFF_PTR0    = 8'h18;
  localparam logic [7:0] OFF_PTR1    = 8'h1C;
  localparam logic [7:0] OFF_PTR2    = 8'h20;
  localparam logic [7:0] OFF_PTR3    = 8'h24;

  // ----------------------------------------
  // Instruction field positions
  // ----------------------------------------
  localparam int POS_ACCESS    = 8;
  localparam int POS_DEST      = 9;
  localparam int POS_BIT_LO    = 9;
  localparam int POS_CALL_FAST = 8;
  localparam int POS_RET_FAST  = 0;
  localparam int POS_PTR_LO    = 4;
  localparam logic [3:0] SECOND_WORD_TAG = 4'hF;

  // ----------------------------------------
  // Flag bit positions
  // ----------------------------------------
  localparam int FLAG_CARRY  = 0;
  localparam int FLAG_DIGIT  = 1;
  localparam int FLAG_ZERO   = 2;
  localparam int FLAG_RANGE  = 3;
  localparam int FLAG_NEG    = 4;

  // ----------------------------------------
  // Reset values and fixed banks
  // ----------------------------------------
  localparam logic [3:0]  ACCESS_BANK   = 4'h0;
  localparam logic [3:0]  RST_BANK      = 4'h0;
  localparam logic [7:0]  RST_WORK      = 8'h00;
  localparam logic [4:0]  RST_FLAGS     = 5'h00;
  localparam logic [20:0] RST_TABLE_POINTER    = 21'h000000;
  localparam logic [11:0] RST_PTR       = 12'h000;

  // Table pointer modes
  localparam logic [1:0] TBL_KEEP    = 2'h0;
  localparam logic [1:0] TBL_POSTINC = 2'h1;
  localparam logic [1:0] TBL_POSTDEC = 2'h2;
  localparam logic [1:0] TBL_PREINC  = 2'h3;

  // Operand format, given by the opcode map
  typedef enum logic [3:0] {
    FMT_NONE,
    FMT_BYTE,
    FMT_BIT,
    FMT_LIT8,
    FMT_LIT12,
    FMT_LIT20,
    FMT_CALL,
    FMT_RET,
    FMT_MOVE,
    FMT_PTRLOAD,
    FMT_TABLE,
    FMT_BRREL8,
    FMT_BRREL11,
    FMT_INDEXED
  } ofd_fmt_t;

  // Pending double-word kind
  typedef enum logic [1:0] {
    DW_NONE,
    DW_LIT20,
    DW_MOVE,
    DW_PTR
  } ofd_dw_t;

endpackage

//--- rtl/ofd_top.sv
// Design decisions made here: the register addresses and the plain strobed port.
`timescale 1ns/10ps
module ofd_top
  import ofd_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rstn,
  input  wire logic [15:0] instrWord,
  input  wire logic        instrValid,
  input  wire ofd_fmt_t    fmtSel,
  input  wire logic [7:0]  aluResult,
  input  wire logic        resultValid,
  input  wire logic [4:0]  flagIn,
  input  wire logic [4:0]  flagWe,
  input  wire logic [15:0] mulProduct,
  input  wire logic        mulValid,
  input  wire logic [7:0]  tblData,
  input  wire logic        tblDataValid,
  input  wire logic [7:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  output logic             opValid,
  output logic             nopWord,
  output logic [11:0]      fileAddr,
  output logic             accessRam,
  output logic             destIsFile,
  output logic [2:0]       bitSel,
  output logic [7:0]       bitMask,
  output logic [19:0]      literal,
  output logic             shadowSave,
  output logic             shadowRestore,
  output logic             tblAccess,
  output logic [20:0]      tblAddr,
  output logic             branchValid,
  output logic             branchRel,
  output logic [20:0]      branchTarget,
  output logic             moveValid,
  output logic [11:0]      srcAddr,
  output logic [11:0]      dstAddr,
  output logic [11:0]      idxAddr,
  output logic             fileWe,
  output logic [11:0]      fileWaddr,
  output logic [7:0]       fileWdata
);

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [31:0]       rdata;
    logic              opValid;
    logic              nopWord;
    logic [11:0]       fileAddr;
    logic              accessRam;
    logic              destIsFile;
    logic [2:0]        bitSel;
    logic [7:0]        bitMask;
    logic [19:0]       literal;
    logic              shadowSave;
    logic              shadowRestore;
    logic              tblAccess;
    logic [20:0]       tblAddr;
    logic              branchValid;
    logic              branchRel;
    logic [20:0]       branchTarget;
    logic              moveValid;
    logic [11:0]       srcAddr;
    logic [11:0]       dstAddr;
    logic [11:0]       idxAddr;
    logic              fileWe;
    logic [11:0]       fileWaddr;
    logic [7:0]        fileWdata;
    ofd_dw_t           dwKind;
    logic              dwFast;
    logic [11:0]       dwFirst;
    logic [3:0]        bank;
    logic [7:0]        work;
    logic [4:0]        flags;
    logic [20:0]       table_pointer;
    logic [7:0]        tblLatch;
    logic [7:0]        prodHigh;
    logic [7:0]        prodLow;
    logic [3:0][11:0]  ptr;
    logic [3:0]        shBank;
    logic [7:0]        shWork;
    logic [4:0]        shFlags;
  } ofd_state_t;

  ofd_state_t st_q;
  ofd_state_t st_d;

  always_comb
  begin
    logic [7:0]  fld8;
    logic [3:0]  selBank;
    logic [20:0] nextPtr;
    logic [1:0]  mode;
    fld8    = instrWord[7:0];
    selBank = RST_BANK;
    nextPtr = RST_TABLE_POINTER;
    mode    = instrWord[1:0];
    st_d    = st_q;

    // Pulses last one cycle
    st_d.opValid       = 1'b0;
    st_d.nopWord       = 1'b0;
    st_d.shadowSave    = 1'b0;
    st_d.shadowRestore = 1'b0;
    st_d.tblAccess     = 1'b0;
    st_d.branchValid   = 1'b0;
    st_d.moveValid     = 1'b0;
    st_d.fileWe        = 1'b0;
    st_d.rdata         = 32'h00000000;

    // ----------------------------------------
    // Register bus
    // ----------------------------------------
    if (regRd)
    begin
      case (regAddr)
        OFF_BANK:    st_d.rdata = {28'h0000000, st_q.bank};
        OFF_WORK:    st_d.rdata = {24'h000000, st_q.work};
        OFF_FLAGS:   st_d.rdata = {27'h0000000, st_q.flags};
        OFF_TABLE_POINTER:  st_d.rdata = {11'h000, st_q.table_pointer};
        OFF_TBLLAT:  st_d.rdata = {24'h000000, st_q.tblLatch};
        OFF_PRODUCT: st_d.rdata = {16'h0000, st_q.prodHigh, st_q.prodLow};
        OFF_PTR0:    st_d.rdata = {20'h00000, st_q.ptr[0]};
        OFF_PTR1:    st_d.rdata = {20'h00000, st_q.ptr[1]};
        OFF_PTR2:    st_d.rdata = {20'h00000, st_q.ptr[2]};
        OFF_PTR3:    st_d.rdata = {20'h00000, st_q.ptr[3]};
        default:     st_d.rdata = 32'h00000000;
      endcase
    end
    if (regWr)
    begin
      case (regAddr)
        OFF_BANK:    st_d.bank = regWdata[3:0];
        OFF_WORK:    st_d.work = regWdata[7:0];
        OFF_FLAGS:   st_d.flags = regWdata[4:0];
        OFF_TABLE_POINTER:  st_d.table_pointer = regWdata[20:0];
        OFF_TBLLAT:  st_d.tblLatch = regWdata[7:0];
        OFF_PRODUCT:
        begin
          st_d.prodHigh = regWdata[15:8];
          st_d.prodLow  = regWdata[7:0];
        end
        OFF_PTR0:    st_d.ptr[0] = regWdata[11:0];
        OFF_PTR1:    st_d.ptr[1] = regWdata[11:0];
        OFF_PTR2:    st_d.ptr[2] = regWdata[11:0];
        OFF_PTR3:    st_d.ptr[3] = regWdata[11:0];
        default:     st_d.rdata = st_d.rdata;
      endcase
    end

    // ----------------------------------------
    // Datapath results, win over bus writes
    // ----------------------------------------
    if (resultValid)
    begin
      if (st_q.destIsFile)
      begin
        st_d.fileWe    = 1'b1;
        st_d.fileWaddr = st_q.fileAddr;
        st_d.fileWdata = aluResult;
      end
      else
      begin
        st_d.work = aluResult;
      end
    end
    for (int i = 0; i < 5; i++)
    begin
      if (flagWe[i])
      begin
        st_d.flags[i] = flagIn[i];
      end
    end
    if (mulValid)
    begin
      st_d.prodHigh = mulProduct[15:8];
      st_d.prodLow  = mulProduct[7:0];
    end
    if (tblDataValid)
    begin
      st_d.tblLatch = tblData;
    end

    // ----------------------------------------
    // Instruction decode
    // ----------------------------------------
    if (instrValid)
    begin
      if (instrWord[15:12] == SECOND_WORD_TAG)
      begin
        st_d.opValid = 1'b1;
        st_d.dwKind  = DW_NONE;
        case (st_q.dwKind)
          DW_LIT20:
          begin
            st_d.literal      = {instrWord[11:0], st_q.dwFirst[7:0]};
            st_d.branchValid  = 1'b1;
            st_d.branchRel    = 1'b0;
            st_d.branchTarget = {1'b0, instrWord[11:0], st_q.dwFirst[7:0]};
            st_d.shadowSave   = st_q.dwFast;
            if (st_q.dwFast)
            begin
              st_d.shBank  = st_d.bank;
              st_d.shWork  = st_d.work;
              st_d.shFlags = st_d.flags;
            end
          end
          DW_MOVE:
          begin
            st_d.dstAddr   = instrWord[11:0];
            st_d.moveValid = 1'b1;
          end
          DW_PTR:
          begin
            st_d.literal = {8'h00, st_q.dwFirst[3:0], fld8};
            st_d.ptr[st_q.dwFirst[POS_PTR_LO+1:POS_PTR_LO]] = {st_q.dwFirst[3:0], fld8};
          end
          default:
          begin
            st_d.nopWord = 1'b1;
          end
        endcase
      end
      else
      begin
        st_d.opValid = 1'b1;
        st_d.dwKind  = DW_NONE;
        case (fmtSel)
          FMT_BYTE, FMT_BIT:
          begin
            selBank            = instrWord[POS_ACCESS] ? st_d.bank : ACCESS_BANK;
            st_d.accessRam     = ~instrWord[POS_ACCESS];
            st_d.fileAddr      = {selBank, fld8};
            st_d.destIsFile    = (fmtSel == FMT_BYTE) ? instrWord[POS_DEST] : 1'b0;
            if (fmtSel == FMT_BIT)
            begin
              st_d.bitSel  = instrWord[POS_BIT_LO+2:POS_BIT_LO];
              st_d.bitMask = 8'h01 << instrWord[POS_BIT_LO+2:POS_BIT_LO];
            end
          end
          FMT_LIT8:
          begin
            st_d.literal    = {12'h000, fld8};
            st_d.destIsFile = 1'b0;
          end
          FMT_LIT12:
          begin
            st_d.literal = {8'h00, instrWord[11:0]};
          end
          FMT_LIT20, FMT_CALL:
          begin
            st_d.dwKind  = DW_LIT20;
            st_d.dwFirst = {4'h0, fld8};
            st_d.dwFast  = (fmtSel == FMT_CALL) ? instrWord[POS_CALL_FAST] : 1'b0;
          end
          FMT_RET:
          begin
            if (instrWord[POS_RET_FAST])
            begin
              st_d.shadowRestore = 1'b1;
              st_d.bank          = st_q.shBank;
              st_d.work          = st_q.shWork;
              st_d.flags         = st_q.shFlags;
            end
          end
          FMT_MOVE:
          begin
            st_d.dwKind  = DW_MOVE;
            st_d.srcAddr = instrWord[11:0];
          end
          FMT_PTRLOAD:
          begin
            st_d.dwKind  = DW_PTR;
            st_d.dwFirst = {6'h00, instrWord[5:0]};
          end
          FMT_TABLE:
          begin
            st_d.tblAccess = 1'b1;
            st_d.tblAddr   = (mode == TBL_PREINC) ? st_d.table_pointer + 21'h000001 : st_d.table_pointer;
            case (mode)
              TBL_POSTINC: nextPtr = st_d.table_pointer + 21'h000001;
              TBL_POSTDEC: nextPtr = st_d.table_pointer - 21'h000001;
              TBL_PREINC:  nextPtr = st_d.table_pointer + 21'h000001;
              default:     nextPtr = st_d.table_pointer;
            endcase
            st_d.table_pointer = nextPtr;
          end
          FMT_BRREL8:
          begin
            st_d.branchValid  = 1'b1;
            st_d.branchRel    = 1'b1;
            st_d.branchTarget = {{13{fld8[7]}}, fld8};
          end
          FMT_BRREL11:
          begin
            st_d.branchValid  = 1'b1;
            st_d.branchRel    = 1'b1;
            st_d.branchTarget = {{10{instrWord[10]}}, instrWord[10:0]};
          end
          FMT_INDEXED:
          begin
            st_d.idxAddr  = st_d.ptr[2] + {5'h00, instrWord[6:0]};
            st_d.fileAddr = st_d.idxAddr;
          end
          default:
          begin
            st_d.opValid = 1'b1;
          end
        endcase
      end
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge clk)
  begin
    if (!rstn)
    begin
      st_q        <= '0;
      st_q.bank   <= RST_BANK;
      st_q.work   <= RST_WORK;
      st_q.flags  <= RST_FLAGS;
      st_q.table_pointer <= RST_TABLE_POINTER;
      st_q.ptr    <= {4{RST_PTR}};
      st_q.dwKind <= DW_NONE;
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign regRdata      = st_q.rdata;
  assign opValid       = st_q.opValid;
  assign nopWord       = st_q.nopWord;
  assign fileAddr      = st_q.fileAddr;
  assign accessRam     = st_q.accessRam;
  assign destIsFile    = st_q.destIsFile;
  assign bitSel        = st_q.bitSel;
  assign bitMask       = st_q.bitMask;
  assign literal       = st_q.literal;
  assign shadowSave    = st_q.shadowSave;
  assign shadowRestore = st_q.shadowRestore;
  assign tblAccess     = st_q.tblAccess;
  assign tblAddr       = st_q.tblAddr;
  assign branchValid   = st_q.branchValid;
  assign branchRel     = st_q.branchRel;
  assign branchTarget  = st_q.branchTarget;
  assign moveValid     = st_q.moveValid;
  assign srcAddr       = st_q.srcAddr;
  assign dstAddr       = st_q.dstAddr;
  assign idxAddr       = st_q.idxAddr;
  assign fileWe        = st_q.fileWe;
  assign fileWaddr     = st_q.fileWaddr;
  assign fileWdata     = st_q.fileWdata;

endmodule

//--- testbench/ofd_checker.sv
`timescale 1ns/10ps
module ofd_checker
  import ofd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rstn,
  input wire logic [15:0] instrWord,
  input wire logic        instrValid,
  input wire ofd_fmt_t    fmtSel,
  input wire logic [7:0]  aluResult,
  input wire logic        resultValid,
  input wire logic        opValid,
  input wire logic        nopWord,
  input wire logic [11:0] fileAddr,
  input wire logic        destIsFile,
  input wire logic [2:0]  bitSel,
  input wire logic [7:0]  bitMask,
  input wire logic        shadowSave,
  input wire logic        shadowRestore,
  input wire logic        branchValid,
  input wire logic        branchRel,
  input wire logic [20:0] branchTarget,
  input wire logic        moveValid,
  input wire logic [11:0] dstAddr,
  input wire logic        fileWe,
  input wire logic [11:0] fileWaddr,
  input wire logic [7:0]  fileWdata
);
  logic dec;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);

  // Word decoded on its own
  assign dec = instrValid && (instrWord[15:12] != SECOND_WORD_TAG);

  property p_access_bank;
    dec && fmtSel == FMT_BYTE && !instrWord[POS_ACCESS] |=> fileAddr == {ACCESS_BANK, $past(instrWord[7:0])};
  endproperty
  a_access_bank: assert property (p_access_bank) else $error("access bank not used");
  property p_dest_sel;
    dec && fmtSel == FMT_BYTE |=> destIsFile == $past(instrWord[POS_DEST]);
  endproperty
  a_dest_sel: assert property (p_dest_sel) else $error("destination select wrong");
  property p_bit_sel;
    dec && fmtSel == FMT_BIT |=> bitSel == $past(instrWord[11:9]) && bitMask == (8'h01 << $past(instrWord[11:9]));
  endproperty
  a_bit_sel: assert property (p_bit_sel) else $error("bit select wrong");
  property p_file_write;
    resultValid && destIsFile |=> fileWe && fileWdata == $past(aluResult) && fileWaddr == $past(fileAddr);
  endproperty
  a_file_write: assert property (p_file_write) else $error("file write missing");
  property p_no_write;
    resultValid && !destIsFile |=> !fileWe;
  endproperty
  a_no_write: assert property (p_no_write) else $error("file written for working dest");
  property p_ret_shadow;
    dec && fmtSel == FMT_RET |=> shadowRestore == $past(instrWord[POS_RET_FAST]);
  endproperty
  a_ret_shadow: assert property (p_ret_shadow) else $error("shadow restore wrong");
  property p_rel_branch;
    dec && fmtSel == FMT_BRREL8 |=> branchValid && branchRel
      && branchTarget == {{13{$past(instrWord[7])}}, $past(instrWord[7:0])};
  endproperty
  a_rel_branch: assert property (p_rel_branch) else $error("relative branch wrong");
  property p_move_pair;
    moveValid |-> dstAddr == $past(instrWord[11:0]) && $past(instrWord[15:12]) == SECOND_WORD_TAG;
  endproperty
  a_move_pair: assert property (p_move_pair) else $error("move target wrong");
  property p_lone_nop;
    nopWord |-> opValid && !moveValid && !branchValid && !shadowSave;
  endproperty
  a_lone_nop: assert property (p_lone_nop) else $error("lone second word acted");
  property p_op_pulse;
    $past(rstn) |-> opValid == $past(instrValid);
  endproperty
  a_op_pulse: assert property (p_op_pulse) else $error("decode pulse wrong");
endmodule

bind ofd_top ofd_checker u_chk (.clk, .rstn, .instrWord, .instrValid, .fmtSel, .aluResult, .resultValid,
  .opValid, .nopWord, .fileAddr, .destIsFile, .bitSel, .bitMask, .shadowSave, .shadowRestore,
  .branchValid, .branchRel, .branchTarget, .moveValid, .dstAddr, .fileWe, .fileWaddr, .fileWdata);

//--- testbench/tb.sv
`timescale 1ns/10ps
module tb
  import ofd_pkg::*;
;
  logic        clk, rstn, instrValid, resultValid, mulValid, tblDataValid, regWr, regRd;
  logic        opValid, nopWord, accessRam, destIsFile, shadowSave, shadowRestore, tblAccess;
  logic        branchValid, branchRel, moveValid, fileWe;
  logic [15:0] instrWord, mulProduct;
  ofd_fmt_t    fmtSel;
  logic [7:0]  aluResult, tblData, regAddr, bitMask, fileWdata;
  logic [4:0]  flagIn, flagWe;
  logic [31:0] regWdata, regRdata;
  logic [11:0] fileAddr, srcAddr, dstAddr, idxAddr, fileWaddr;
  logic [2:0]  bitSel;
  logic [19:0] literal;
  logic [20:0] tblAddr, branchTarget, p;
  int          error_cnt, checked;

  ofd_top u_dut (.clk, .rstn, .instrWord, .instrValid, .fmtSel, .aluResult, .resultValid, .flagIn,
    .flagWe, .mulProduct, .mulValid, .tblData, .tblDataValid, .regAddr, .regWdata, .regWr, .regRd,
    .regRdata, .opValid, .nopWord, .fileAddr, .accessRam, .destIsFile, .bitSel, .bitMask, .literal,
    .shadowSave, .shadowRestore, .tblAccess, .tblAddr, .branchValid, .branchRel, .branchTarget,
    .moveValid, .srcAddr, .dstAddr, .idxAddr, .fileWe, .fileWaddr, .fileWdata);

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  // ----
  // Bus and check tasks
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    regAddr  <= a;
    regWdata <= d;
    regWr    <= 1'b1;
    @(posedge clk);
    regWr <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk);
    regAddr <= a;
    regRd   <= 1'b1;
    @(posedge clk);
    regRd <= 1'b0;
    #1;
    chk(regRdata, e);
  endtask

  task automatic op(input logic [15:0] w, input ofd_fmt_t f);
    @(posedge clk);
    instrWord  <= w;
    fmtSel     <= f;
    instrValid <= 1'b1;
    @(posedge clk);
    instrValid <= 1'b0;
    #1;
  endtask

  task automatic res(input logic [7:0] v);
    @(posedge clk);
    aluResult   <= v;
    resultValid <= 1'b1;
    @(posedge clk);
    resultValid <= 1'b0;
    #1;
  endtask

  task automatic final_report;
    if (error_cnt == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  // ----
  // Main sequence
  // ----
  initial
  begin
    {rstn, instrValid, resultValid, mulValid, tblDataValid, regWr, regRd} = 7'h00;
    {instrWord, mulProduct, aluResult, tblData, regAddr} = 56'h0;
    {flagIn, flagWe, regWdata} = 42'h0;
    fmtSel = FMT_NONE;
    error_cnt = 0;
    checked = 0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    #1;
    chk({opValid, fileWe, shadowSave, tblAccess, moveValid}, 32'h0);
    for (int i = 0; i < 10; i++) rdc(8'(i * 4), 32'h0);
    rdc(8'h40, 32'h0);
    wr(OFF_BANK, 32'h5);
    rdc(OFF_BANK, 32'h5);
    op(16'h273C, FMT_BYTE);
    chk(32'(fileAddr), 32'h53C);
    chk(32'(destIsFile), 32'h1);
    chk(32'(accessRam), 32'h0);
    res(8'hA5);
    chk({fileWe, 11'h0, fileWaddr, fileWdata}, 32'h8005_3CA5);
    op(16'h2481, FMT_BYTE);
    chk(32'(fileAddr), 32'({ACCESS_BANK, 8'h81}));
    chk(32'(accessRam), 32'h1);
    res(8'h3C);
    chk(32'(fileWe), 32'h0);
    rdc(OFF_WORK, 32'h3C);
    for (int b = 0; b < 8; b++)
    begin
      op(16'h8010 | 16'(b << 9), FMT_BIT);
      chk({21'h0, bitSel, bitMask}, 32'((b << 8) | (32'h1 << b)));
    end
    op(16'hF777, FMT_MOVE);
    chk({nopWord, opValid, moveValid}, 32'h6);
    op(16'h0E7F, FMT_LIT8);
    chk(32'(literal), 32'h7F);
    op(16'hEF34, FMT_LIT20);
    chk(32'(opValid), 32'h1);
    op(16'hF123, FMT_NONE);
    chk({branchValid, branchRel, 10'h0, literal}, 32'h8001_2334);
    op(16'hED56, FMT_CALL);
    op(16'hF0AB, FMT_NONE);
    chk({shadowSave, 11'h0, literal}, 32'h8000_AB56);
    op(16'hEC56, FMT_CALL);
    op(16'hF0AB, FMT_NONE);
    chk({shadowSave, branchValid}, 32'h1);
    op(16'h0013, FMT_RET);
    chk(32'(shadowRestore), 32'h1);
    op(16'h0012, FMT_RET);
    chk(32'(shadowRestore), 32'h0);
    op(16'h0FF3, FMT_RET);
    chk(32'(shadowRestore), 32'h1);
    op(16'hC123, FMT_MOVE);
    op(16'hF456, FMT_NONE);
    chk({moveValid, 7'h0, srcAddr, dstAddr}, 32'h8012_3456);
    op(16'hEE1A, FMT_PTRLOAD);
    op(16'hF0BC, FMT_NONE);
    rdc(OFF_PTR1, 32'hABC);
    op(16'hE2F0, FMT_BRREL8);
    chk({branchValid, branchRel, 9'h0, branchTarget}, 32'hC01FFFF0);
    op(16'hD405, FMT_BRREL11);
    chk({branchRel, 10'h0, branchTarget}, 32'h801FFC05);
    wr(OFF_PTR2, 32'h200);
    op(16'h2415, FMT_INDEXED);
    chk(32'(idxAddr), 32'h215);
    wr(OFF_TABLE_POINTER, 32'h1FFFFF);
    p = 21'h1FFFFF;
    for (int m = 0; m < 4; m++)
    begin
      op(16'h0008 | 16'(m), FMT_TABLE);
      if (m == 3) p = p + 21'h1;
      chk({tblAccess, 10'h0, tblAddr}, {11'h400, p});
      if (m == 1) p = p + 21'h1;
      if (m == 2) p = p - 21'h1;
      rdc(OFF_TABLE_POINTER, 32'(p));
    end
    @(posedge clk);
    flagIn <= 5'h15;
    flagWe <= 5'h1F;
    @(posedge clk);
    flagIn <= 5'h00;
    flagWe <= 5'h04;
    @(posedge clk);
    flagWe <= 5'h00;
    rdc(OFF_FLAGS, 32'h11);
    @(posedge clk);
    mulProduct   <= 16'hBEEF;
    mulValid     <= 1'b1;
    tblData      <= 8'h5A;
    tblDataValid <= 1'b1;
    @(posedge clk);
    mulValid     <= 1'b0;
    tblDataValid <= 1'b0;
    rdc(OFF_PRODUCT, 32'hBEEF);
    rdc(OFF_TBLLAT, 32'h5A);
    final_report();
  end
endmodule
